// ==== design/bcp_pkg.sv ====
// Package with constants and carrier types for the buck cycle control block.
package bcp_pkg;

   // ---------------------------------------------------------------
   // Channel and timing constants
   // ---------------------------------------------------------------
   localparam int unsigned NUM_CH         = 3;
   localparam int unsigned PERIOD_BITS    = 8;
   localparam logic [7:0]  PERIOD_DEF     = 8'h0F;
   localparam int unsigned OVL_CYCLES     = 256;
   localparam int unsigned HICCUP_CYCLES  = 8192;
   localparam int unsigned CNT_BITS       = 14;
   localparam int unsigned DEGLITCH_CYCLES = 4;

   // ---------------------------------------------------------------
   // Command register layout
   // ---------------------------------------------------------------
   localparam logic [7:0]  CMD_BASE_ADDR  = 8'h03;
   localparam int unsigned CMD_EN_BIT     = 0;
   localparam int unsigned CMD_MODE_BIT   = 1;
   localparam logic [7:0]  CMD_RESET      = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic en_thresh;
      logic en_bias;
      logic ss_below_ref;
      logic ss_arm;
      logic bst_ok;
      logic fb_over;
      logic ipk_trip;
      logic izero;
      logic comp_low;
      logic ls_src_lim;
      logic ls_snk_lim;
      logic overload;
   } bcp_cmp_type;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } bcp_gate_type;

   typedef enum logic [3:0] {
      BCP_OFF    = 4'b0001,
      BCP_RUN    = 4'b0010,
      BCP_HICCUP = 4'b0100,
      BCP_BOOT   = 4'b1000
   } bcp_state_type;

endpackage

// ==== design/bcp_top.sv ====
// Three-channel switching-cycle control, protection and start-up logic.
//
// Notes on behaviour
// - Ramp voltage below reference selects ramp as the regulation target.
// - Power-ok stays low until ramp reaches 1.2 V, then after deglitch.
// - Enable near 0.4 V turns bias regulator on before channel enable.
// - Past enabling threshold, extra 3.0 uA hysteresis source is switched in.
// - Supply lockout forces every converter off and stops switching.
// - Bootstrap below 2.1 V forces high-side off and low-side on.
// - First channel cycle start is PERIOD/2 clocks after channels two and three, 7 of 16 by default.
// - Overvoltage holds high-side off; resumes at next cycle start.
// - Pulse-skip ends each high-side pulse on 310 mA peak trip.
// - Pulse-skip turns low-side off at inductor zero current.
// - Pulse-skip suspends switching while error amplifier below 0.35 V.
// - Current trip ends high-side pulse and turns low-side on.
// - Low-side source limit at cycle end skips next high-side pulse.
// - Low-side sink limit turns both switches off until next cycle.
// - Overload beyond 256 cycles shuts down, waits 8192, restarts soft-start.
// - Each channel has an 8-bit command register; bit 0 enable, bit 1 mode.
`timescale 1ns/1ps
module bcp_top #(
   parameter int unsigned        OVL_LIMIT    = bcp_pkg::OVL_CYCLES,
   parameter int unsigned        HICCUP_LIMIT = bcp_pkg::HICCUP_CYCLES,
   parameter logic [7:0]         PERIOD       = bcp_pkg::PERIOD_DEF
) (
   input  wire logic                                mclk,
   input  wire logic                                rst_b,
   input  wire logic                                supply_ok,
   input  wire bcp_pkg::bcp_cmp_type [2:0]          cmp_in,
   input  wire logic                                cmd_wr,
   input  wire logic [7:0]                          cmd_addr,
   input  wire logic [7:0]                          cmd_wdata,
   output logic [7:0]                               cmd_rdata,
   output bcp_pkg::bcp_gate_type [2:0]              gate_out,
   output logic [2:0]                               use_ramp_ref,
   output logic [2:0]                               internal_bias_regulator,
   output logic [2:0]                               hyst_source_on,
   output logic [2:0]                               power_ok_output,
   output logic [2:0]                               cycle_start,
   output logic [2:0]                               hiccup_active
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   bcp_pkg::bcp_cmp_type [2:0] cmp_m_q;
   bcp_pkg::bcp_cmp_type [2:0] cmp_q;
   logic                       sup_m_q;
   logic                       sup_q;

   // Analogue levels are read only after the second flop.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cmp_m_q <= '0;
         cmp_q   <= '0;
         sup_m_q <= 1'b0;
         sup_q   <= 1'b0;
      end else begin
         cmp_m_q <= cmp_in;
         cmp_q   <= cmp_m_q;
         sup_m_q <= supply_ok;
         sup_q   <= sup_m_q;
      end
   end

   // ---------------------------------------------------------------
   // Command registers
   // ---------------------------------------------------------------
   logic [2:0][7:0] cmd_q;

   function automatic logic [1:0] cmd_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - bcp_pkg::CMD_BASE_ADDR;
      cmd_index = d[1:0];
   endfunction

   function automatic logic cmd_hit(input logic [7:0] a);
      cmd_hit = (a >= bcp_pkg::CMD_BASE_ADDR) &&
                (a < bcp_pkg::CMD_BASE_ADDR + 8'h03);
   endfunction

   // Only the mode and enable bits are stored; the rest read as zero.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cmd_q <= {3{bcp_pkg::CMD_RESET}};
      end else if (cmd_wr && cmd_hit(cmd_addr)) begin
         cmd_q[cmd_index(cmd_addr)] <= {6'h00, cmd_wdata[1:0]};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cmd_rdata <= 8'h00;
      end else if (cmd_hit(cmd_addr)) begin
         cmd_rdata <= cmd_q[cmd_index(cmd_addr)];
      end else begin
         cmd_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Cycle timebase: channel 0 starts PERIOD/2 clocks after channels 1, 2
   // ---------------------------------------------------------------
   logic [7:0] per_q;
   logic [7:0] half;
   logic       start_a;
   logic       start_b;

   // Starts decode single counter values, so each lasts one clock.
   assign half    = {1'b0, PERIOD[7:1]};
   assign start_a = (per_q == 8'h00);
   assign start_b = (per_q == half);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         per_q <= 8'h00;
      end else if (per_q == PERIOD) begin
         per_q <= 8'h00;
      end else begin
         per_q <= per_q + 8'h01;
      end
   end

   assign cycle_start = {start_a, start_a, start_b};

   // ---------------------------------------------------------------
   // Per-channel control
   // ---------------------------------------------------------------
   bcp_pkg::bcp_state_type [2:0]          st_q;
   logic [2:0][bcp_pkg::CNT_BITS-1:0]     cnt_q;
   logic [2:0]                            hs_q;
   logic [2:0]                            ls_q;
   logic [2:0]                            skip_q;
   logic [2:0]                            snk_off_q;
   logic [2:0]                            armed_q;
   logic [2:0][2:0]                       dgl_q;
   logic [2:0]                            pok_q;

   function automatic logic [bcp_pkg::CNT_BITS-1:0] cnt_next(
      input logic [bcp_pkg::CNT_BITS-1:0] v);
      cnt_next = v + 1'b1;
   endfunction

   for (genvar c = 0; c < 3; c++) begin : g_ch
      logic en_ok;
      logic pulse_skip_operation;
      logic halt;
      logic ovl_hit;
      assign pulse_skip_operation   = cmd_q[c][bcp_pkg::CMD_MODE_BIT];
      assign en_ok = sup_q && cmp_q[c].en_thresh &&
                     cmd_q[c][bcp_pkg::CMD_EN_BIT];
      assign halt  = pulse_skip_operation && cmp_q[c].comp_low;
      // Shutdown drops the gates on the same edge that enters hiccup.
      assign ovl_hit = cycle_start[c] && cmp_q[c].overload &&
                       (cnt_q[c] == OVL_LIMIT[bcp_pkg::CNT_BITS-1:0]);

      // ------------------------------------------------------------
      // Start-up state, overload and hiccup counting
      // ------------------------------------------------------------
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            st_q[c]  <= bcp_pkg::BCP_OFF;
            cnt_q[c] <= '0;
         end else if (!en_ok) begin
            st_q[c]  <= bcp_pkg::BCP_OFF;
            cnt_q[c] <= '0;
         end else begin
            case (st_q[c])
               bcp_pkg::BCP_OFF: begin
                  st_q[c]  <= bcp_pkg::BCP_RUN;
                  cnt_q[c] <= '0;
               end
               bcp_pkg::BCP_RUN: begin
                  if (cycle_start[c]) begin
                     if (!cmp_q[c].overload) begin
                        cnt_q[c] <= '0;
                     end else if (ovl_hit) begin
                        st_q[c]  <= bcp_pkg::BCP_HICCUP;
                        cnt_q[c] <= '0;
                     end else begin
                        cnt_q[c] <= cnt_next(cnt_q[c]);
                     end
                  end
               end
               bcp_pkg::BCP_HICCUP: begin
                  // The wait counts cycle starts, not clocks.
                  if (cycle_start[c]) begin
                     if (cnt_q[c] ==
                         HICCUP_LIMIT[bcp_pkg::CNT_BITS-1:0] - 1'b1) begin
                        st_q[c]  <= bcp_pkg::BCP_BOOT;
                        cnt_q[c] <= '0;
                     end else begin
                        cnt_q[c] <= cnt_next(cnt_q[c]);
                     end
                  end
               end
               bcp_pkg::BCP_BOOT: begin
                  // Restart waits for the ramp to be discharged.
                  if (cmp_q[c].ss_below_ref) begin
                     st_q[c] <= bcp_pkg::BCP_RUN;
                  end
               end
               default: begin
                  st_q[c] <= bcp_pkg::BCP_OFF;
               end
            endcase
         end
      end

      // ------------------------------------------------------------
      // Gate drive within each switching cycle
      // ------------------------------------------------------------
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            hs_q[c]      <= 1'b0;
            ls_q[c]      <= 1'b0;
            skip_q[c]    <= 1'b0;
            snk_off_q[c] <= 1'b0;
         end else if (st_q[c] != bcp_pkg::BCP_RUN || !en_ok ||
                      ovl_hit) begin
            hs_q[c]      <= 1'b0;
            ls_q[c]      <= 1'b0;
            skip_q[c]    <= 1'b0;
            snk_off_q[c] <= 1'b0;
         end else if (!cmp_q[c].bst_ok) begin
            // A low bootstrap overrides the cycle so it can recharge.
            hs_q[c] <= 1'b0;
            ls_q[c] <= 1'b1;
         end else if (cycle_start[c]) begin
            snk_off_q[c] <= 1'b0;
            // A source overload seen at the start skips the high pulse.
            skip_q[c]    <= cmp_q[c].ls_src_lim;
            if (cmp_q[c].ls_src_lim || cmp_q[c].fb_over || halt) begin
               hs_q[c] <= 1'b0;
               ls_q[c] <= cmp_q[c].ls_src_lim;
            end else begin
               hs_q[c] <= 1'b1;
               ls_q[c] <= 1'b0;
            end
         end else if (cmp_q[c].ls_snk_lim && ls_q[c]) begin
            hs_q[c]      <= 1'b0;
            ls_q[c]      <= 1'b0;
            snk_off_q[c] <= 1'b1;
         end else if (hs_q[c] && (cmp_q[c].fb_over ||
                      (pulse_skip_operation && cmp_q[c].ipk_trip) ||
                      cmp_q[c].ipk_trip)) begin
            hs_q[c] <= 1'b0;
            // A sink overload already seen keeps the low side off.
            ls_q[c] <= !snk_off_q[c] && !cmp_q[c].ls_snk_lim;
         end else if (ls_q[c] && pulse_skip_operation && cmp_q[c].izero && !skip_q[c]) begin
            ls_q[c] <= 1'b0;
         end
      end

      // ------------------------------------------------------------
      // Power-ok arming and deglitch
      // ------------------------------------------------------------
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            armed_q[c] <= 1'b0;
            dgl_q[c]   <= '0;
            pok_q[c]   <= 1'b0;
         end else if (st_q[c] != bcp_pkg::BCP_RUN) begin
            armed_q[c] <= 1'b0;
            dgl_q[c]   <= '0;
            pok_q[c]   <= 1'b0;
         end else begin
            // Once armed, the monitor stays armed until the channel stops.
            if (cmp_q[c].ss_arm) begin
               armed_q[c] <= 1'b1;
            end
            if (armed_q[c] && dgl_q[c] !=
                bcp_pkg::DEGLITCH_CYCLES[2:0]) begin
               dgl_q[c] <= dgl_q[c] + 3'h1;
            end
            pok_q[c] <= armed_q[c] &&
                        (dgl_q[c] == bcp_pkg::DEGLITCH_CYCLES[2:0]);
         end
      end

      // ------------------------------------------------------------
      // Start-up control levels
      // ------------------------------------------------------------
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            use_ramp_ref[c]            <= 1'b1;
            internal_bias_regulator[c] <= 1'b0;
            hyst_source_on[c]          <= 1'b0;
         end else begin
            use_ramp_ref[c]            <= cmp_q[c].ss_below_ref;
            internal_bias_regulator[c] <= cmp_q[c].en_bias && sup_q;
            hyst_source_on[c]          <= cmp_q[c].en_thresh;
         end
      end

      assign gate_out[c].hs_on  = hs_q[c];
      assign gate_out[c].ls_on  = ls_q[c];
      assign power_ok_output[c] = pok_q[c];
      assign hiccup_active[c]   = (st_q[c] == bcp_pkg::BCP_HICCUP);
   end

endmodule // bcp_top

// ==== tb/bcp_checker.sv ====
// Concurrent assertions on the buck cycle control ports.
`timescale 1ns/1ps
module bcp_checker #(
   parameter logic [7:0] PERIOD = bcp_pkg::PERIOD_DEF
) (
   input wire logic                        mclk,
   input wire logic                        rst_b,
   input wire logic                        supply_ok,
   input wire bcp_pkg::bcp_cmp_type [2:0]  cmp_in,
   input wire logic [7:0]                  cmd_rdata,
   input wire bcp_pkg::bcp_gate_type [2:0] gate_out,
   input wire logic [2:0]                  use_ramp_ref,
   input wire logic [2:0]                  internal_bias_regulator,
   input wire logic [2:0]                  hyst_source_on,
   input wire logic [2:0]                  power_ok_output,
   input wire logic [2:0]                  cycle_start,
   input wire logic [2:0]                  hiccup_active
);
   localparam int CYC = PERIOD + 1;
   localparam int HALF = PERIOD / 2;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_lockout_off: assert property (!supply_ok [*5] |-> gate_out == '0)
      else $error("gates active in supply lockout");
   a_ramp_target: assert property (cmp_in[0].ss_below_ref [*4]
      |-> use_ramp_ref[0]) else $error("ramp target not selected");
   a_pok_disarmed: assert property (!cmp_in[0].ss_arm [*4]
      |-> !power_ok_output[0]) else $error("power ok while disarmed");
   a_bias_on: assert property ((cmp_in[0].en_bias && supply_ok) [*4]
      |-> internal_bias_regulator[0]) else $error("bias regulator off");
   a_hyst_on: assert property (cmp_in[0].en_thresh [*4]
      |-> hyst_source_on[0]) else $error("hysteresis source off");
   a_ovp_hs_off: assert property (cmp_in[0].fb_over [*5]
      |-> !gate_out[0].hs_on) else $error("high side on in overvoltage");
   a_gate_excl: assert property (gate_out[0] != 2'h3 &&
      gate_out[1] != 2'h3 && gate_out[2] != 2'h3)
      else $error("both switches on");
   a_phase_shift: assert property (cycle_start[1]
      |-> cycle_start[2] ##HALF cycle_start[0])
      else $error("channel one not half a cycle apart");
   a_cycle_period: assert property (cycle_start[1]
      |-> ##CYC cycle_start[1]) else $error("cycle period wrong");
   a_hiccup_off: assert property (hiccup_active[1]
      |-> gate_out[1] == 2'h0) else $error("gates on in hiccup");
   a_cmd_width: assert property (cmd_rdata[7:2] == 6'h00)
      else $error("unused command bits set");
endmodule // bcp_checker
bind bcp_top bcp_checker #(.PERIOD(PERIOD)) bcp_checker_i (
   .mclk(mclk), .rst_b(rst_b), .supply_ok(supply_ok), .cmp_in(cmp_in),
   .cmd_rdata(cmd_rdata), .gate_out(gate_out), .use_ramp_ref(use_ramp_ref),
   .internal_bias_regulator(internal_bias_regulator),
   .hyst_source_on(hyst_source_on), .power_ok_output(power_ok_output),
   .cycle_start(cycle_start), .hiccup_active(hiccup_active));

// ==== tb/bcp_cmp_model.sv ====
// Behavioural model of the current comparators facing the gate drives.
`timescale 1ns/1ps
module bcp_cmp_model (
   input  wire logic                        mclk,
   input  wire bcp_pkg::bcp_gate_type [2:0] gate_out,
   input  wire bcp_pkg::bcp_cmp_type [2:0]  base,
   output bcp_pkg::bcp_cmp_type [2:0]       cmp_in
);
   logic [1:0] hs_q [3];
   logic [1:0] ls_q [3];
   // Inductor current rises while high side conducts, falls on low side.
   always_ff @(posedge mclk) begin
      for (int k = 0; k < 3; k++) begin
         hs_q[k] <= gate_out[k].hs_on ? hs_q[k] + (hs_q[k] != 2'h3) : 2'h0;
         ls_q[k] <= gate_out[k].ls_on ? ls_q[k] + (ls_q[k] != 2'h3) : 2'h0;
      end
   end
   always_comb begin
      cmp_in = base;
      for (int k = 0; k < 3; k++) begin
         cmp_in[k].ipk_trip = base[k].ipk_trip |
                              (hs_q[k] >= 2'h2);
         cmp_in[k].izero = base[k].izero | (ls_q[k] >= 2'h2);
      end
   end
endmodule // bcp_cmp_model

// ==== tb/bcp_top_tb.sv ====
// Self-checking testbench for the buck cycle control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module bcp_top_tb;
   localparam int CYC = 16;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic supply_ok = 1'b0;
   logic cmd_wr = 1'b0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic [7:0] cmd_rdata;
   bcp_pkg::bcp_cmp_type [2:0] base = '0;
   bcp_pkg::bcp_cmp_type [2:0] cmp_in;
   bcp_pkg::bcp_gate_type [2:0] gate_out;
   logic [2:0] use_ramp_ref, internal_bias_regulator, hyst_source_on;
   logic [2:0] power_ok_output, cycle_start, hiccup_active;
   logic [1:0] shadow [3] = '{2'h0, 2'h0, 2'h0};
   logic [31:0] seed = 32'hf718_6ba7;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int hs, ls, n;
   bcp_top #(.OVL_LIMIT(4), .HICCUP_LIMIT(8), .PERIOD(8'h0F)) bcp_top_i (
      .mclk(mclk), .rst_b(rst_b), .supply_ok(supply_ok), .cmp_in(cmp_in),
      .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_rdata(cmd_rdata), .gate_out(gate_out), .use_ramp_ref(use_ramp_ref),
      .internal_bias_regulator(internal_bias_regulator),
      .hyst_source_on(hyst_source_on), .power_ok_output(power_ok_output),
      .cycle_start(cycle_start), .hiccup_active(hiccup_active));
   bcp_cmp_model bcp_cmp_model_i (.mclk(mclk), .gate_out(gate_out),
      .base(base), .cmp_in(cmp_in));
   initial forever #20 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return (a >= 8'h03 && a <= 8'h05) ? {6'h00, shadow[a - 8'h03]} : 8'h00;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      {cmd_wr, cmd_addr, cmd_wdata} = {1'b1, a, d};
      @(negedge mclk);
      cmd_wr = 1'b0;
      if (a >= 8'h03 && a <= 8'h05) shadow[a - 8'h03] = d[1:0];
   endtask
   task automatic watch(input int ch, input int len);
      hs = 0;
      ls = 0;
      repeat (len) begin
         @(negedge mclk);
         hs += (gate_out[ch].hs_on === 1'b1);
         ls += (gate_out[ch].ls_on === 1'b1);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(negedge mclk);
      `CHK("reset gates", 6'h00, gate_out)
      `CHK("reset ramp", 3'h7, use_ramp_ref)
      rst_b = 1'b1;
      for (int a = 2; a < 8; a++) begin
         seed = xs(seed);
         wr(a[7:0], seed[7:0]);
         cmd_addr = a[7:0];
         @(negedge mclk);
         `CHK("cmd_rdata", exp_rd(a[7:0]), cmd_rdata)
      end
      for (int k = 0; k < 3; k++) begin
         base[k] = 12'hF80;
         wr(8'h03 + k[7:0], 8'h01);
      end
      supply_ok = 1'b1;
      watch(0, 3 * CYC);
      `CHK("pulse ends", 1'b1, hs > 0 && hs < 2 * CYC && ls > 0)
      `CHK("power ok", 3'h7, power_ok_output)
      `CHK("bias", 3'h7, internal_bias_regulator)
      `CHK("hyst", 3'h7, hyst_source_on)
      base[0].bst_ok = 1'b0;
      watch(0, 5);
      watch(0, CYC);
      `CHK("boot recharge", 1'b1, hs == 0 && ls == CYC)
      {base[0].bst_ok, base[0].fb_over} = 2'b11;
      watch(0, 5);
      watch(0, 2 * CYC);
      `CHK("ovp hold", 0, hs)
      base[0].fb_over = 1'b0;
      watch(0, 2 * CYC);
      `CHK("ovp resume", 1'b1, hs > 0)
      base[1].ls_src_lim = 1'b1;
      base[2].ls_snk_lim = 1'b1;
      watch(1, CYC + 5);
      watch(1, 2 * CYC);
      `CHK("source skip", 1'b1, hs == 0 && ls == 2 * CYC)
      watch(2, 2 * CYC);
      `CHK("sink off", 0, ls)
      {base[1].ls_src_lim, base[2].ls_snk_lim} = 2'b00;
      wr(8'h03, 8'h03);
      base[0].comp_low = 1'b1;
      watch(0, CYC + 5);
      watch(0, 2 * CYC);
      `CHK("skip idle", 0, hs)
      base[0].comp_low = 1'b0;
      watch(0, 5);
      watch(0, 2 * CYC);
      `CHK("no reverse", 1'b1, hs > 0 && hs + ls < 2 * CYC)
      base[1].overload = 1'b1;
      n = 0;
      while (hiccup_active[1] !== 1'b1 && n < 7 * CYC) begin
         @(negedge mclk);
         n++;
      end
      `CHK("hiccup entry", 1'b1, n > 3 * CYC && n < 7 * CYC)
      base[1].overload = 1'b0;
      n = 0;
      while (hiccup_active[1] === 1'b1 && n < 10 * CYC) begin
         @(negedge mclk);
         n++;
      end
      `CHK("hiccup wait", 1'b1, n >= 7 * CYC && n <= 9 * CYC)
      watch(1, 3 * CYC);
      `CHK("restart", 1'b1, hs > 0)
      supply_ok = 1'b0;
      watch(0, 6);
      `CHK("lockout", 6'h00, gate_out)
      wrap_up();
   end
endmodule // bcp_top_tb
